// >>> shared/ook_slicer_pkg.sv
package ook_slicer_pkg;

    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [2:0] ADDR_CTRL   = 3'h0;
    localparam logic [2:0] ADDR_FIXED  = 3'h1;
    localparam logic [2:0] ADDR_OFFSET = 3'h2;
    localparam logic [2:0] ADDR_PEAK   = 3'h3;
    localparam logic [2:0] ADDR_THRESH = 3'h4;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    localparam int CTRL_MODE_BIT  = 0;
    localparam int CTRL_DECAY_BIT = 1;
    localparam int CTRL_STEP_LSB  = 2;
    localparam int CTRL_RATE_LSB  = 5;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL_RESET   = 8'h06;
    localparam logic [7:0] FIXED_RESET  = 8'h50;
    localparam logic [7:0] OFFSET_RESET = 8'h10;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam logic [3:0] HOLD_SYMS = 4'h8;

    // Decay step per selector, index 7 first
    localparam logic [7:0][3:0] DECAY_STEPS = {4'hF, 4'hC, 4'h9, 4'h6, 4'h5, 4'h3, 4'h2, 4'h1};
    // Half-symbols between decay events: 4, 2, 1, 0.5 symbols
    localparam logic [3:0][3:0] RATE_HALVES = {4'h1, 4'h2, 4'h4, 4'h8};

    typedef enum logic {tracked_peak_mode, fixed_level_mode} slice_mode_t;

endpackage : ook_slicer_pkg

// >>> rtl/bit_fifo.sv
`timescale 1ns/1ps
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // Fill side
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    // Drain side
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [CW-1:0]               cnt;
        logic                        rdy;
        logic                        vld;
    } fifo_state_t;

    fifo_state_t state_q;
    fifo_state_t state_d;

    logic push;
    logic pop;

    assign push      = in_valid && state_q.rdy;
    assign pop       = out_ready && state_q.vld;
    assign in_ready  = state_q.rdy;
    assign out_valid = state_q.vld;
    assign out_data  = state_q.mem[0];

    // Head sits in slot 0 so the output is a plain flop
    always_comb
    begin
        state_d = state_q;
        if (pop)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
                state_d.mem[i] = state_q.mem[i+1];
        end
        if (push)
            state_d.mem[CW'(state_q.cnt - CW'(pop))] = in_data;
        state_d.cnt = CW'(state_q.cnt + CW'(push) - CW'(pop));
        state_d.rdy = state_d.cnt != CW'(DEPTH);
        state_d.vld = state_d.cnt != '0;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_q <= '{mem: '0, cnt: '0, rdy: 1'b1, vld: 1'b0};
        else
            state_q <= state_d;
    end

    full_stall_a: assert property (@(posedge clk) disable iff (rst)
        state_q.cnt == CW'(DEPTH) |-> !in_ready && out_valid)
        else $error("fifo full but still ready");

endmodule : bit_fifo

// >>> rtl/peak_window.sv
`timescale 1ns/1ps
module peak_window #(
    parameter int SYMS = 8
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Samples and symbol timing
    input  wire logic [7:0] sample,
    input  wire logic       sample_valid,
    input  wire logic       sym_stb,
    // Window maximum
    output logic [7:0]      max_q
);
    typedef struct packed {
        logic [SYMS-1:0][7:0] slot;
        logic [7:0]           cur;
        logic [7:0]           max;
    } win_state_t;

    win_state_t state_q;
    win_state_t state_d;

    assign max_q = state_q.max;

    // Current symbol's max plus the previous SYMS-1 symbols
    always_comb
    begin
        state_d = state_q;
        if (sample_valid && sample > state_q.cur)
            state_d.cur = sample;
        if (sym_stb)
        begin
            for (int i = SYMS - 1; i > 0; i--)
                state_d.slot[i] = state_q.slot[i-1];
            state_d.slot[0] = state_d.cur;
            state_d.cur = sample_valid ? sample : 8'h00;
        end
        state_d.max = state_d.cur;
        for (int i = 0; i < SYMS - 1; i++)
        begin
            if (state_d.slot[i] > state_d.max)
                state_d.max = state_d.slot[i];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            state_q <= '0;
        else
            state_q <= state_d;
    end

endmodule : peak_window

// >>> rtl/ook_threshold_slicer.sv
`timescale 1ns/1ps
module ook_threshold_slicer #(
    parameter int FIFO_DEPTH = 4,
    parameter int HOLD_WIN   = 8
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Register port
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    // Signal strength samples
    input  wire logic [7:0] rssi,
    input  wire logic       rssi_valid,
    output logic            rssi_ready,
    // Symbol timing
    input  wire logic       sym_stb,
    input  wire logic       half_stb,
    // Demodulated stream to packet decoder
    output logic            demod_bit,
    output logic            demod_valid,
    input  wire logic       demod_ready
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] fixed;
        logic [7:0] offset;
        logic [7:0] rdata;
        logic [7:0] peak;
        logic [7:0] thresh;
        logic [3:0] hold;
        logic [3:0] div;
    } slicer_state_t;

    slicer_state_t state_q;
    slicer_state_t state_d;

    ook_slicer_pkg::slice_mode_t mode;

    logic       decay_en;
    logic [7:0] step;
    logic [3:0] period;
    logic [7:0] win_max;
    logic [7:0] peak_eff;
    logic [7:0] thresh;
    logic       bit_out;
    logic       push;
    logic       fifo_ready;
    logic       tick;

    // ----------------------------------------
    // Control decode
    // ----------------------------------------
    assign mode     = ook_slicer_pkg::slice_mode_t'(state_q.ctrl[ook_slicer_pkg::CTRL_MODE_BIT]);
    assign decay_en = state_q.ctrl[ook_slicer_pkg::CTRL_DECAY_BIT]
                      && mode == ook_slicer_pkg::tracked_peak_mode;
    assign step     = {4'h0, ook_slicer_pkg::DECAY_STEPS[state_q.ctrl[ook_slicer_pkg::CTRL_STEP_LSB +: 3]]};
    assign period   = ook_slicer_pkg::RATE_HALVES[state_q.ctrl[ook_slicer_pkg::CTRL_RATE_LSB +: 2]];
    // Every strobe is a half-symbol, so 0.5-symbol rate needs half_stb
    assign tick     = sym_stb || half_stb;

    // ----------------------------------------
    // Slicing
    // ----------------------------------------
    peak_window #(
        .SYMS         (HOLD_WIN)
    ) u_window (
        .clk          (clk),
        .rst          (rst),
        .sample       (rssi),
        .sample_valid (rssi_valid),
        .sym_stb      (sym_stb),
        .max_q        (win_max)
    );

    always_comb
    begin
        // Window result lags a cycle, so fold the live sample in
        if (decay_en)
            peak_eff = state_q.peak;
        else if (rssi_valid && rssi > win_max)
            peak_eff = rssi;
        else
            peak_eff = win_max;
        if (mode == ook_slicer_pkg::fixed_level_mode)
            thresh = state_q.fixed;
        else if (peak_eff > state_q.offset)
            thresh = peak_eff - state_q.offset;
        else
            thresh = 8'h00;
    end

    assign bit_out = rssi > thresh;
    assign push    = rssi_valid && fifo_ready;

    bit_fifo #(
        .WIDTH     (1),
        .DEPTH     (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_data   (bit_out),
        .in_valid  (rssi_valid),
        .in_ready  (fifo_ready),
        .out_data  (demod_bit),
        .out_valid (demod_valid),
        .out_ready (demod_ready)
    );

    assign rssi_ready = fifo_ready;
    assign rdata      = state_q.rdata;

    // ----------------------------------------
    // Registers, peak tracking and decay
    // ----------------------------------------
    always_comb
    begin
        state_d        = state_q;
        state_d.thresh = thresh;
        state_d.rdata  = 8'h00;
        if (wr)
        begin
            if (addr == ook_slicer_pkg::ADDR_CTRL)
                state_d.ctrl = {1'b0, wdata[6:0]};
            else if (addr == ook_slicer_pkg::ADDR_FIXED)
                state_d.fixed = wdata;
            else if (addr == ook_slicer_pkg::ADDR_OFFSET)
                state_d.offset = wdata;
        end
        if (rd)
        begin
            if (addr == ook_slicer_pkg::ADDR_CTRL)
                state_d.rdata = state_q.ctrl;
            else if (addr == ook_slicer_pkg::ADDR_FIXED)
                state_d.rdata = state_q.fixed;
            else if (addr == ook_slicer_pkg::ADDR_OFFSET)
                state_d.rdata = state_q.offset;
            else if (addr == ook_slicer_pkg::ADDR_PEAK)
                state_d.rdata = peak_eff;
            else if (addr == ook_slicer_pkg::ADDR_THRESH)
                state_d.rdata = state_q.thresh;
        end
        // A larger sample always wins over a decay tick
        if (rssi_valid && rssi > state_q.peak)
        begin
            state_d.peak = rssi;
            state_d.hold = 4'h0;
            state_d.div  = 4'h0;
        end
        else if (state_q.hold != ook_slicer_pkg::HOLD_SYMS)
        begin
            if (sym_stb)
                state_d.hold = 4'(state_q.hold + 4'h1);
        end
        else if (decay_en && tick)
        begin
            if (4'(state_q.div + 4'h1) >= period)
            begin
                state_d.div  = 4'h0;
                state_d.peak = (state_q.peak > step) ? 8'(state_q.peak - step) : 8'h00;
            end
            else
                state_d.div = 4'(state_q.div + 4'h1);
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q        <= '0;
            state_q.ctrl   <= ook_slicer_pkg::CTRL_RESET;
            state_q.fixed  <= ook_slicer_pkg::FIXED_RESET;
            state_q.offset <= ook_slicer_pkg::OFFSET_RESET;
        end
        else
            state_q <= state_d;
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence fixed_write_s;
        wr && addr == ook_slicer_pkg::ADDR_FIXED;
    endsequence

    sequence bigger_sample_s;
        rssi_valid && rssi > state_q.peak;
    endsequence

    fixed_level_write_a: assert property (
        fixed_write_s |=> state_q.fixed == $past(wdata))
        else $error("fixed level not written");

    fixed_slice_a: assert property (
        push && mode == ook_slicer_pkg::fixed_level_mode |-> bit_out == (rssi > state_q.fixed))
        else $error("fixed slice wrong");

    peak_thresh_a: assert property (
        mode == ook_slicer_pkg::tracked_peak_mode && peak_eff >= state_q.offset
        |=> state_q.thresh == 8'($past(peak_eff) - $past(state_q.offset)))
        else $error("peak threshold wrong");

    peak_capture_a: assert property (
        bigger_sample_s |=> state_q.peak == $past(rssi) && state_q.hold == 4'h0)
        else $error("peak not captured");

    hold_no_drop_a: assert property (
        state_q.hold != ook_slicer_pkg::HOLD_SYMS |=> state_q.peak >= $past(state_q.peak))
        else $error("peak dropped during hold");

    decay_amount_a: assert property (
        state_q.peak < $past(state_q.peak) && !$past(rssi_valid && rssi > state_q.peak)
        |-> state_q.peak == 8'h00 || 8'($past(state_q.peak) - state_q.peak) == $past(step))
        else $error("decay step wrong");

    decay_off_a: assert property (
        !decay_en |=> state_q.peak >= $past(state_q.peak))
        else $error("peak decayed while decay off");

    read_answer_a: assert property (
        rd && addr == ook_slicer_pkg::ADDR_CTRL ##1 !rd |-> rdata == $past(state_q.ctrl) ##1 rdata == 8'h00)
        else $error("read data not one cycle");

endmodule : ook_threshold_slicer

// >>> verification/decoder_model.sv
`timescale 1ns/1ps
// ------------------------------
// Packet decoder stand-in
// ------------------------------
module decoder_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Demodulated stream
    input  wire logic demod_bit,
    input  wire logic demod_valid,
    output logic      demod_ready,
    // Bench control
    input  wire logic stall
);
    logic got[$];

    // Stalling lets the bench back up the FIFO
    assign demod_ready = !stall;

    always @(posedge clk)
        if (!rst && demod_valid && demod_ready)
        begin
            got.push_back(demod_bit);
        end
endmodule : decoder_model

// >>> verification/tb.sv
`timescale 1ns/1ps
module tb;
    logic       clk;
    logic       rst;
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [7:0] rssi;
    logic       rssi_valid;
    logic       rssi_ready;
    logic       sym_stb;
    logic       half_stb;
    logic       demod_bit;
    logic       demod_valid;
    logic       demod_ready;
    logic       stall;
    int         errors;
    int         check_count;
    int         steps[8] = '{1, 2, 3, 5, 6, 9, 12, 15};

    ook_threshold_slicer u_ook_threshold_slicer (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .rssi(rssi), .rssi_valid(rssi_valid), .rssi_ready(rssi_ready),
        .sym_stb(sym_stb), .half_stb(half_stb), .demod_bit(demod_bit), .demod_valid(demod_valid),
        .demod_ready(demod_ready));
    decoder_model u_decoder_model (.clk(clk), .rst(rst), .demod_bit(demod_bit), .demod_valid(demod_valid),
        .demod_ready(demod_ready), .stall(stall));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ------------------------------
    // Reporting and bus tasks
    // ------------------------------
    task automatic stop_test();
        $display("errors=%0d checks=%0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : stop_test

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t byte %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk1(input logic got, input logic exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH t=%0t bit %b exp %b", $time, got, exp);
        end
    endtask : chk1

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk8(rdata, exp);
    endtask : rd_chk

    task automatic push(input logic [7:0] v);
        @(posedge clk);
        rssi       <= v;
        rssi_valid <= 1'b1;
        @(posedge clk);
        rssi_valid <= 1'b0;
    endtask : push

    // One symbol: start strobe, then mid-symbol strobe
    task automatic sym(input int n);
        repeat (n)
        begin
            @(posedge clk);
            sym_stb <= 1'b1;
            @(posedge clk);
            sym_stb  <= 1'b0;
            half_stb <= 1'b1;
            @(posedge clk);
            half_stb <= 1'b0;
        end
    endtask : sym

    task automatic reset_dut();
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask : reset_dut

    // ------------------------------
    // Scenarios
    // ------------------------------
    task automatic test_reset();
        rd_chk(ook_slicer_pkg::ADDR_CTRL, 8'h06);
        rd_chk(ook_slicer_pkg::ADDR_FIXED, 8'h50);
        rd_chk(ook_slicer_pkg::ADDR_OFFSET, 8'h10);
        rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'h00);
        wr_reg(3'h7, 8'hFF);
        rd_chk(3'h7, 8'h00);
    endtask : test_reset

    task automatic test_fixed();
        logic [7:0] v[5] = '{8'h50, 8'h51, 8'h00, 8'hFF, 8'h60};
        u_decoder_model.got.delete();
        stall <= 1'b1;
        wr_reg(ook_slicer_pkg::ADDR_CTRL, 8'h07);
        foreach (v[i])
            push(v[i]);
        #1;
        chk1(rssi_ready, 1'b0);
        chk1(demod_valid, 1'b1);
        chk1(demod_bit, 1'b0);
        stall <= 1'b0;
        repeat (10) @(posedge clk);
        chk8(8'(u_decoder_model.got.size()), 8'h04);
        for (int i = 0; i < 4; i++)
            chk1(u_decoder_model.got[i], v[i] > 8'h50);
    endtask : test_fixed

    task automatic test_window();
        wr_reg(ook_slicer_pkg::ADDR_CTRL, 8'h00);
        for (int i = 0; i < 9; i++)
        begin
            push(8'h20);
            sym(1);
        end
        rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'h20);
        push(8'h90);
        push(8'h85);
        push(8'h80);
        rd_chk(ook_slicer_pkg::ADDR_THRESH, 8'h80);
        chk1(u_decoder_model.got[$ - 1], 1'b1);
        chk1(u_decoder_model.got[$], 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            push(8'h20);
            sym(1);
            if (i == 6)
                rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'h90);
        end
        rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'h20);
    endtask : test_window

    task automatic test_default_decay();
        // Peak kept from the fixed-level samples would mask the new one
        reset_dut();
        rd_chk(ook_slicer_pkg::ADDR_CTRL, 8'h06);
        rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'h00);
        wr_reg(ook_slicer_pkg::ADDR_CTRL, 8'h06);
        push(8'hEF);
        sym(8);
        rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'hEF);
        sym(4);
        rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'hED);
        sym(472);
        rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'h01);
        sym(4);
        rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'h00);
    endtask : test_default_decay

    // Each step code paired with a rate code; period counted in half-symbols
    task automatic test_decay_codes();
        for (int i = 0; i < 8; i++)
        begin
            wr_reg(ook_slicer_pkg::ADDR_CTRL, {1'b0, 2'(i % 4), 3'(i), 2'b10});
            push(8'hEF);
            sym(8);
            for (int m = 0; m < 5; m++)
            begin
                rd_chk(ook_slicer_pkg::ADDR_PEAK, 8'(239 - steps[i] * ((1 + 2 * m) / (8 >> (i % 4)))));
                sym(1);
            end
        end
    endtask : test_decay_codes

    initial
    begin
        errors      = 0;
        check_count = 0;
        rst         = 1'b1;
        addr        = 3'h0;
        wdata       = 8'h00;
        wr          = 1'b0;
        rd          = 1'b0;
        rssi        = 8'h00;
        rssi_valid  = 1'b0;
        sym_stb     = 1'b0;
        half_stb    = 1'b0;
        stall       = 1'b0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        test_reset();
        test_fixed();
        test_window();
        test_default_decay();
        test_decay_codes();
        stop_test();
    end

    // Whole run is a few thousand cycles
    initial
    begin
        #100000;
        errors++;
        stop_test();
    end
endmodule : tb
